/* hdl/sfrb_bank.sv */
// sfrb_bank: bank 2/3 special function registers behind a wishbone slave,
// with the core datapath hooks for flags, program counter and sleep events.
// assumes: one 100 MHz clock, synchronous active-high reset, one master.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module sfrb_bank #(
  parameter bit WIDE_NVM = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [10:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pc_load_i,
  input wire logic [7:0] pc_load_low_i,
  input wire logic flags_upd_i,
  input wire logic zero_flag_i,
  input wire logic digit_carry_flag_i,
  input wire logic carry_flag_i,
  input wire logic wdt_timeout_i,
  input wire logic sleep_i,
  input wire logic clrwdt_i,
  input wire logic [7:0] port_pins_i,
  output logic [12:0] pc_o,
  output logic [7:0] core_flags_o,
  output logic [7:0] core_irq_control_o,
  output logic [7:0] timer0_count_o,
  output logic [7:0] timer_option_o,
  output logic [7:0] port_latch_o,
  output logic [7:0] port_direction_o,
  output logic [7:0] nvm_data_low_o,
  output logic [7:0] nvm_addr_low_o,
  output logic [5:0] nvm_data_high_o,
  output logic [4:0] nvm_addr_high_o,
  output logic [4:0] nvm_control_o,
  output logic nvm_unlock_o,
  output logic [7:0] nvm_unlock_data_o
);
  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [12:0] pc;
    logic [4:0] pclatch;
    logic [7:0] flags;
    logic [7:0] ptr;
    logic [7:0] irq;
    logic [7:0] tmr;
    logic [7:0] opt;
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] nvd_lo;
    logic [7:0] nva_lo;
    logic [5:0] nvd_hi;
    logic [4:0] nva_hi;
    logic [4:0] nvcon;
    logic unlock;
    logic [7:0] unlock_dat;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
  } sfrb_state_s;

  sfrb_state_s st;
  sfrb_state_s next_st;
  logic req;
  logic [8:0] direct_idx;
  logic [8:0] eff_idx;
  logic [7:0] wdat;
  logic do_write;
  logic [4:0] nva_mask;

  // --------------------------------------------------------------------
  // address resolution
  // --------------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i;
  assign wdat = wb_dat_i[7:0];
  // writes land at the edge where the master sees ack
  assign do_write = req & st.ack & wb_we_i & wb_sel_i[0];
  // bit 4 only on the larger variant
  assign nva_mask = WIDE_NVM ? 5'h1f : 5'h0f;

  // low window takes the bank from the bank select bits
  always_comb begin
    if (wb_adr_i[10]) begin
      direct_idx = wb_adr_i[10:2];
    end else begin
      direct_idx = {st.flags[sfrb_pkg::FLG_BANK_HI], st.flags[sfrb_pkg::FLG_BANK_LO],
                    wb_adr_i[8:2]};
    end
  end

  // indirect port accesses go to the location the pointer names
  always_comb begin
    if (direct_idx[8] && direct_idx[6:0] == sfrb_pkg::OFS_INDIRECT_PORT) begin
      eff_idx = {st.flags[sfrb_pkg::FLG_IRP], st.ptr};
    end else begin
      eff_idx = direct_idx;
    end
  end

  // read mux; shared registers match on the in-bank offset only
  function automatic logic [7:0] read_reg(input logic [8:0] idx, input sfrb_state_s s,
                                          input logic [4:0] msk);
    logic [7:0] v;
    v = 8'h00;
    // no read path exists for counter bits 12..8
    if (idx[8]) begin
      unique case (idx[6:0])
        sfrb_pkg::OFS_PC_LOW_BYTE: v = s.pc[7:0];
        sfrb_pkg::OFS_CORE_FLAGS: v = s.flags;
        sfrb_pkg::OFS_INDIRECT_POINTER: v = s.ptr;
        sfrb_pkg::OFS_PC_HIGH_LATCH: v = {3'h0, s.pclatch};
        sfrb_pkg::OFS_CORE_IRQ_CONTROL: v = s.irq;
        default: begin
          unique case (idx)
            sfrb_pkg::IDX_TIMER0_COUNT: v = s.tmr;
            sfrb_pkg::IDX_PIN_PORT_TWO_DATA: v = s.pin_sync;
            sfrb_pkg::IDX_NVM_DATA_LOW: v = s.nvd_lo;
            sfrb_pkg::IDX_NVM_ADDR_LOW: v = s.nva_lo;
            sfrb_pkg::IDX_NVM_DATA_HIGH: v = {2'h0, s.nvd_hi};
            sfrb_pkg::IDX_NVM_ADDR_HIGH: v = {3'h0, s.nva_hi & msk};
            sfrb_pkg::IDX_TIMER_OPTION_CFG: v = s.opt;
            sfrb_pkg::IDX_PIN_PORT_TWO_DIRECTION: v = s.dir;
            sfrb_pkg::IDX_NVM_CONTROL: v = {s.nvcon[4], 3'h0, s.nvcon[3:0]};
            default: v = 8'h00;
          endcase
        end
      endcase
    end
    return v;
  endfunction

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.unlock = 1'b0;
    // pins pass two flip-flops before anything reads them
    next_st.pin_meta = port_pins_i;
    next_st.pin_sync = st.pin_meta;
    // one-cycle ack, dropped the cycle after it is given
    next_st.ack = req & ~st.ack;
    if (req && !st.ack) begin
      next_st.rdat = read_reg(eff_idx, st, nva_mask);
    end
    // register writes; unlisted locations and bits fall through
    if (do_write && eff_idx[8]) begin
      unique case (eff_idx[6:0])
        sfrb_pkg::OFS_PC_LOW_BYTE: begin
          // writing the low byte loads the counter with the latch
          next_st.pc = {st.pclatch, wdat};
        end
        sfrb_pkg::OFS_CORE_FLAGS: begin
          // timeout and powerdown keep their value on writes
          next_st.flags = {wdat[7:5], st.flags[4:3], wdat[2:0]};
        end
        sfrb_pkg::OFS_INDIRECT_POINTER: next_st.ptr = wdat;
        // only five bits of the latch are stored
        sfrb_pkg::OFS_PC_HIGH_LATCH: next_st.pclatch = wdat[4:0];
        sfrb_pkg::OFS_CORE_IRQ_CONTROL: next_st.irq = wdat;
        default: begin
          unique case (eff_idx)
            sfrb_pkg::IDX_TIMER0_COUNT: next_st.tmr = wdat;
            sfrb_pkg::IDX_PIN_PORT_TWO_DATA: next_st.latch = wdat;
            sfrb_pkg::IDX_NVM_DATA_LOW: next_st.nvd_lo = wdat;
            sfrb_pkg::IDX_NVM_ADDR_LOW: next_st.nva_lo = wdat;
            sfrb_pkg::IDX_NVM_DATA_HIGH: next_st.nvd_hi = wdat[5:0];
            // bit 4 stored only on the larger variant
            sfrb_pkg::IDX_NVM_ADDR_HIGH: next_st.nva_hi = wdat[4:0] & nva_mask;
            sfrb_pkg::IDX_TIMER_OPTION_CFG: next_st.opt = wdat;
            sfrb_pkg::IDX_PIN_PORT_TWO_DIRECTION: next_st.dir = wdat;
            sfrb_pkg::IDX_NVM_CONTROL: next_st.nvcon = {wdat[7], wdat[3:0]};
            sfrb_pkg::IDX_NVM_UNLOCK_SEQUENCE: begin
              // no storage: a write is passed on as a pulse
              next_st.unlock = 1'b1;
              next_st.unlock_dat = wdat;
            end
            default: next_st.tmr = st.tmr;
          endcase
        end
      endcase
    end
    // a core counter load copies the latch into bits 12..8
    if (pc_load_i) begin
      next_st.pc = {st.pclatch, pc_load_low_i};
    end
    // flag results win over a software write to those bits
    if (flags_upd_i) begin
      next_st.flags[sfrb_pkg::FLG_ZERO] = zero_flag_i;
      next_st.flags[sfrb_pkg::FLG_DIGIT_CARRY] = digit_carry_flag_i;
      next_st.flags[sfrb_pkg::FLG_CARRY] = carry_flag_i;
    end
    // only watchdog, sleep and clear-watchdog events move these bits
    if (clrwdt_i) begin
      next_st.flags[sfrb_pkg::FLG_TIMEOUT] = 1'b1;
      next_st.flags[sfrb_pkg::FLG_POWERDOWN] = 1'b1;
    end else if (sleep_i) begin
      next_st.flags[sfrb_pkg::FLG_TIMEOUT] = 1'b1;
      next_st.flags[sfrb_pkg::FLG_POWERDOWN] = 1'b0;
    end else if (wdt_timeout_i) begin
      next_st.flags[sfrb_pkg::FLG_TIMEOUT] = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  // power-up values; the power bits come up set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.flags <= sfrb_pkg::RST_CORE_FLAGS;
      st.opt <= sfrb_pkg::RST_TIMER_OPTION;
      st.dir <= sfrb_pkg::RST_PORT_DIRECTION;
      st.pclatch <= sfrb_pkg::RST_PC_HIGH_LATCH;
      st.pc <= sfrb_pkg::RST_PC;
      st.irq <= sfrb_pkg::RST_ZERO_BYTE;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state
  assign wb_ack_o = st.ack;
  assign wb_dat_o = {24'h000000, st.rdat};
  assign pc_o = st.pc;
  assign core_flags_o = st.flags;
  assign core_irq_control_o = st.irq;
  assign timer0_count_o = st.tmr;
  assign timer_option_o = st.opt;
  assign port_latch_o = st.latch;
  assign port_direction_o = st.dir;
  assign nvm_data_low_o = st.nvd_lo;
  assign nvm_addr_low_o = st.nva_lo;
  assign nvm_data_high_o = st.nvd_hi;
  assign nvm_addr_high_o = st.nva_hi;
  assign nvm_control_o = st.nvcon;
  assign nvm_unlock_o = st.unlock;
  assign nvm_unlock_data_o = st.unlock_dat;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req |=> s_ack_once) else $error("ack not a one-cycle answer");

  chk_pc_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    pc_load_i |=> pc_o == {$past(st.pclatch), $past(pc_load_low_i)})
    else $error("counter load did not take the holding latch");

  chk_pc_high_guard: assert property (@(posedge clk_i) disable iff (rst_i)
    !pc_load_i && !(do_write && eff_idx[6:0] == sfrb_pkg::OFS_PC_LOW_BYTE && eff_idx[8])
    |=> $stable(pc_o[12:8])) else $error("counter high part changed without a load");

  chk_latch_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req ##0 (eff_idx[8] && eff_idx[6:0] == sfrb_pkg::OFS_PC_HIGH_LATCH)
    |=> wb_dat_o[7:5] == 3'h0) else $error("latch upper bits not zero");

  chk_mirror_read: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req ##0 (eff_idx[8] && eff_idx[6:0] == sfrb_pkg::OFS_INDIRECT_POINTER)
    |=> wb_dat_o[7:0] == $past(st.ptr)) else $error("pointer copy differs by bank");

  chk_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req ##0 (!eff_idx[8] || eff_idx == sfrb_pkg::IDX_RESERVED_SLOT_A)
    |=> wb_dat_o == 32'h00000000) else $error("unmapped location read non-zero");

  chk_nva_narrow: assert property (@(posedge clk_i) disable iff (rst_i)
    !WIDE_NVM |-> nvm_addr_high_o[sfrb_pkg::NVA_WIDE_BIT] == 1'b0)
    else $error("narrow variant holds address bit 4");

  chk_bank_select: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_adr_i[10] |-> direct_idx[8:7] == core_flags_o[6:5])
    else $error("direct bank not taken from bank bits");

  chk_indirect_path: assert property (@(posedge clk_i) disable iff (rst_i)
    (direct_idx[8] && direct_idx[6:0] == sfrb_pkg::OFS_INDIRECT_PORT)
    |-> eff_idx == {core_flags_o[7], st.ptr}) else $error("indirect port not redirected");

  chk_flags_win: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_upd_i |=> core_flags_o[2:0] ==
    {$past(zero_flag_i), $past(digit_carry_flag_i), $past(carry_flag_i)})
    else $error("flag results lost to a write");

  chk_power_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    !clrwdt_i && !sleep_i && !wdt_timeout_i |=> $stable(core_flags_o[4:3]))
    else $error("timeout or powerdown changed without an event");

  // what a write leaves behind, and what the core events do to the flags
  chk_latch_store: assert property (@(posedge clk_i) disable iff (rst_i)
    do_write && eff_idx[8] && eff_idx[6:0] == sfrb_pkg::OFS_PC_HIGH_LATCH
    |=> {3'h0, st.pclatch} == ($past(wdat) & 8'h1f))
    else $error("latch kept more than five bits");

  chk_ptr_store: assert property (@(posedge clk_i) disable iff (rst_i)
    do_write && eff_idx[8] && eff_idx[6:0] == sfrb_pkg::OFS_INDIRECT_POINTER
    |=> st.ptr == $past(wdat))
    else $error("pointer write lost in one bank");

  chk_irq_store: assert property (@(posedge clk_i) disable iff (rst_i)
    do_write && eff_idx[8] && eff_idx[6:0] == sfrb_pkg::OFS_CORE_IRQ_CONTROL
    |=> core_irq_control_o == $past(wdat))
    else $error("irq control write lost in one bank");

  chk_unlock_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    s_wb_req ##0 (eff_idx == sfrb_pkg::IDX_NVM_UNLOCK_SEQUENCE)
    |=> wb_dat_o == 32'h00000000) else $error("unlock location read non-zero");

  chk_reserved_write: assert property (@(posedge clk_i) disable iff (rst_i)
    do_write && eff_idx == sfrb_pkg::IDX_RESERVED_SLOT_B
    |=> $stable(timer_option_o) && $stable(port_direction_o) && $stable(timer0_count_o))
    else $error("reserved write changed a register");

  chk_nva_wide: assert property (@(posedge clk_i) disable iff (rst_i)
    WIDE_NVM && do_write && eff_idx == sfrb_pkg::IDX_NVM_ADDR_HIGH
    |=> {3'h0, nvm_addr_high_o} == ($past(wdat) & 8'h1f))
    else $error("wide variant lost address bit 4");

  chk_indirect_write: assert property (@(posedge clk_i) disable iff (rst_i)
    do_write && direct_idx[8] && direct_idx[6:0] == sfrb_pkg::OFS_INDIRECT_PORT &&
    {core_flags_o[7], st.ptr} == sfrb_pkg::IDX_TIMER_OPTION_CFG
    |=> timer_option_o == $past(wdat)) else $error("indirect write missed its target");

  chk_bank_three: assert property (@(posedge clk_i) disable iff (rst_i)
    do_write && !wb_adr_i[10] && core_flags_o[6:5] == 2'b11 &&
    wb_adr_i[8:2] == sfrb_pkg::IDX_PIN_PORT_TWO_DIRECTION[6:0]
    |=> port_direction_o == $past(wdat)) else $error("bank three write missed direction");

  chk_bank_low: assert property (@(posedge clk_i) disable iff (rst_i)
    do_write && !wb_adr_i[10] && !core_flags_o[sfrb_pkg::FLG_BANK_HI]
    |=> $stable(timer_option_o) && $stable(port_direction_o) && $stable(port_latch_o))
    else $error("low bank write reached this block");

  chk_clear_event: assert property (@(posedge clk_i) disable iff (rst_i)
    clrwdt_i |=> core_flags_o[sfrb_pkg::FLG_TIMEOUT] &&
    core_flags_o[sfrb_pkg::FLG_POWERDOWN]) else $error("clear watchdog left a bit low");

  chk_sleep_event: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_i && !clrwdt_i |=> core_flags_o[sfrb_pkg::FLG_TIMEOUT] &&
    !core_flags_o[sfrb_pkg::FLG_POWERDOWN]) else $error("sleep did not clear powerdown");

  chk_timeout_event: assert property (@(posedge clk_i) disable iff (rst_i)
    wdt_timeout_i && !clrwdt_i && !sleep_i |=> !core_flags_o[sfrb_pkg::FLG_TIMEOUT])
    else $error("watchdog timeout did not clear the timeout bit");
endmodule
`default_nettype wire

/* pkg/sfrb_pkg.sv */
// sfrb_pkg: register indices, field positions and reset values for the
// bank 2/3 special function register block.
// assumes: a classic wishbone slave, byte address = 4 * register index.
package sfrb_pkg;
  // --------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // --------------------------------------------------------------------
  localparam logic [8:0] IDX_INDIRECT_PORT_B2 = 9'h100;
  localparam logic [8:0] IDX_TIMER0_COUNT = 9'h101;
  localparam logic [8:0] IDX_PC_LOW_BYTE_B2 = 9'h102;
  localparam logic [8:0] IDX_CORE_FLAGS_B2 = 9'h103;
  localparam logic [8:0] IDX_INDIRECT_POINTER_B2 = 9'h104;
  localparam logic [8:0] IDX_PIN_PORT_TWO_DATA = 9'h106;
  localparam logic [8:0] IDX_PC_HIGH_LATCH_B2 = 9'h10a;
  localparam logic [8:0] IDX_CORE_IRQ_CONTROL_B2 = 9'h10b;
  localparam logic [8:0] IDX_NVM_DATA_LOW = 9'h10c;
  localparam logic [8:0] IDX_NVM_ADDR_LOW = 9'h10d;
  localparam logic [8:0] IDX_NVM_DATA_HIGH = 9'h10e;
  localparam logic [8:0] IDX_NVM_ADDR_HIGH = 9'h10f;
  localparam logic [8:0] IDX_INDIRECT_PORT_B3 = 9'h180;
  localparam logic [8:0] IDX_TIMER_OPTION_CFG = 9'h181;
  localparam logic [8:0] IDX_PC_LOW_BYTE_B3 = 9'h182;
  localparam logic [8:0] IDX_CORE_FLAGS_B3 = 9'h183;
  localparam logic [8:0] IDX_INDIRECT_POINTER_B3 = 9'h184;
  localparam logic [8:0] IDX_PIN_PORT_TWO_DIRECTION = 9'h186;
  localparam logic [8:0] IDX_PC_HIGH_LATCH_B3 = 9'h18a;
  localparam logic [8:0] IDX_CORE_IRQ_CONTROL_B3 = 9'h18b;
  localparam logic [8:0] IDX_NVM_CONTROL = 9'h18c;
  localparam logic [8:0] IDX_NVM_UNLOCK_SEQUENCE = 9'h18d;
  localparam logic [8:0] IDX_RESERVED_SLOT_A = 9'h18e;
  localparam logic [8:0] IDX_RESERVED_SLOT_B = 9'h18f;
  // in-bank offsets of the registers seen from both banks 2 and 3
  localparam logic [6:0] OFS_INDIRECT_PORT = 7'h00;
  localparam logic [6:0] OFS_PC_LOW_BYTE = 7'h02;
  localparam logic [6:0] OFS_CORE_FLAGS = 7'h03;
  localparam logic [6:0] OFS_INDIRECT_POINTER = 7'h04;
  localparam logic [6:0] OFS_PC_HIGH_LATCH = 7'h0a;
  localparam logic [6:0] OFS_CORE_IRQ_CONTROL = 7'h0b;
  // --------------------------------------------------------------------
  // core flags fields
  // --------------------------------------------------------------------
  localparam int FLG_IRP = 7;
  localparam int FLG_BANK_HI = 6;
  localparam int FLG_BANK_LO = 5;
  localparam int FLG_TIMEOUT = 4;
  localparam int FLG_POWERDOWN = 3;
  localparam int FLG_ZERO = 2;
  localparam int FLG_DIGIT_CARRY = 1;
  localparam int FLG_CARRY = 0;
  localparam int NVA_WIDE_BIT = 4;
  // --------------------------------------------------------------------
  // values after reset
  // --------------------------------------------------------------------
  localparam logic [7:0] RST_CORE_FLAGS = 8'h18;
  localparam logic [7:0] RST_TIMER_OPTION = 8'hff;
  localparam logic [7:0] RST_PORT_DIRECTION = 8'hff;
  localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
  localparam logic [4:0] RST_PC_HIGH_LATCH = 5'h00;
  localparam logic [12:0] RST_PC = 13'h0000;
endpackage

/* dv/sfrb_bank_tb_top.sv */
// sfrb_bank_tb_top: self-checking bench for the bank 2/3 register block.
// assumes: classic wishbone slave acking one cycle after taking a request.
`timescale 1ns/1ns
`default_nettype none
module sfrb_bank_tb_top;
  // ------------------------------------------------------------------
  // clock, reset and stimulus signals
  // ------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [10:0] adr = 11'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic pc_load = 1'b0, fl_upd = 1'b0, z_in = 1'b0, dc_in = 1'b0, c_in = 1'b0;
  logic [7:0] pc_low = 8'h00, pins = 8'h00;
  logic [2:0] evt = 3'h0;
  logic [31:0] dat_o, ndat_o;
  logic ack_o, nack_o;
  logic [12:0] pc_o;
  logic [7:0] flags_o, irq_o, opt_o, latch_o, dir_o, unl_d_o;
  logic [7:0] q, nq;
  logic [7:0] tmr_o, nvdl_o, nval_o;
  logic [5:0] nvdh_o;
  logic [4:0] nvah_o, nvc_o;
  logic unl_o;
  int unl_cnt = 0;
  int mismatches = 0;
  int check_count = 0;
  always #5 clk_i = ~clk_i;
  // counts unlock pulses seen at the clock edge
  always @(posedge clk_i) begin
    if (unl_o === 1'b1) begin
      unl_cnt++;
    end
  end
  // wide and narrow nvm variants share the same request
  sfrb_bank #(.WIDE_NVM(1'b1)) sfrb_bank_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o), .pc_load_i(pc_load),
    .pc_load_low_i(pc_low), .flags_upd_i(fl_upd), .zero_flag_i(z_in),
    .digit_carry_flag_i(dc_in), .carry_flag_i(c_in), .wdt_timeout_i(evt[2]),
    .sleep_i(evt[1]), .clrwdt_i(evt[0]), .port_pins_i(pins), .pc_o(pc_o),
    .core_flags_o(flags_o), .core_irq_control_o(irq_o), .timer0_count_o(tmr_o),
    .timer_option_o(opt_o), .port_latch_o(latch_o), .port_direction_o(dir_o),
    .nvm_data_low_o(nvdl_o), .nvm_addr_low_o(nval_o), .nvm_data_high_o(nvdh_o),
    .nvm_addr_high_o(nvah_o), .nvm_control_o(nvc_o), .nvm_unlock_o(unl_o),
    .nvm_unlock_data_o(unl_d_o));
  sfrb_bank #(.WIDE_NVM(1'b0)) sfrb_bank_narrow_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(ndat_o), .wb_ack_o(nack_o), .pc_load_i(pc_load),
    .pc_load_low_i(pc_low), .flags_upd_i(fl_upd), .zero_flag_i(z_in),
    .digit_carry_flag_i(dc_in), .carry_flag_i(c_in), .wdt_timeout_i(evt[2]),
    .sleep_i(evt[1]), .clrwdt_i(evt[0]), .port_pins_i(pins), .pc_o(),
    .core_flags_o(), .core_irq_control_o(), .timer0_count_o(), .timer_option_o(),
    .port_latch_o(), .port_direction_o(), .nvm_data_low_o(), .nvm_addr_low_o(),
    .nvm_data_high_o(), .nvm_addr_high_o(), .nvm_control_o(), .nvm_unlock_o(),
    .nvm_unlock_data_o());
  // ------------------------------------------------------------------
  // verdict, compare and bus tasks
  // ------------------------------------------------------------------
  task automatic results();
    $display("mismatches %0d, comparisons %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one classic cycle; holds the request until ack is sampled high
  task automatic xfer(input logic w, input logic [8:0] idx, input logic [7:0] d,
                      input logic s0);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= {3'b000, s0};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, ack_o, 1'b1);
    end
    q = dat_o[7:0];
    nq = ndat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 1'b1);
  endtask
  task automatic rd(input logic [8:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00, 1'b1);
    chk({24'h0, q}, {24'h0, exp});
  endtask
  // core event pulse: {timeout, sleep, clear watchdog}
  task automatic core_evt(input logic [2:0] e);
    evt <= e;
    @(posedge clk_i);
    evt <= 3'h0;
    repeat (2) @(posedge clk_i);
  endtask
  // ------------------------------------------------------------------
  // watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(9'h103, 8'h18);
    rd(9'h181, 8'hff);
    rd(9'h186, 8'hff);
    rd(9'h10a, 8'h00);
    rd(9'h18e, 8'h00);
    // shared registers: one store behind both banks
    wr(9'h18a, 8'hff);
    rd(9'h10a, 8'h1f);
    wr(9'h10a, 8'h15);
    rd(9'h18a, 8'h15);
    wr(9'h104, 8'h81);
    rd(9'h184, 8'h81);
    wr(9'h18b, 8'h40);
    rd(9'h10b, 8'h40);
    chk({24'h0, irq_o}, 32'h40);
    // program counter high comes only from the latch
    wr(9'h102, 8'h34);
    chk({19'h0, pc_o}, 32'h1534);
    wr(9'h18a, 8'h0a);
    pc_low <= 8'h78;
    pc_load <= 1'b1;
    @(posedge clk_i);
    pc_load <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({19'h0, pc_o}, 32'h0a78);
    // unimplemented places and bits
    wr(9'h105, 8'hff);
    rd(9'h105, 8'h00);
    wr(9'h18f, 8'hff);
    rd(9'h18f, 8'h00);
    wr(9'h10e, 8'hff);
    rd(9'h10e, 8'h3f);
    chk({26'h0, nvdh_o}, 32'h3f);
    wr(9'h10f, 8'hff);
    rd(9'h10f, 8'h1f);
    chk({27'h0, nvah_o}, 32'h1f);
    chk({24'h0, nq}, 32'h0f);
    xfer(1'b1, 9'h181, 8'h00, 1'b0);
    rd(9'h181, 8'hff);
    // nvm and timer storage, control bits and the unlock location
    wr(9'h10c, 8'h96);
    rd(9'h10c, 8'h96);
    wr(9'h10d, 8'h69);
    chk({16'h0, nvdl_o, nval_o}, 32'h9669);
    wr(9'h18c, 8'hff);
    rd(9'h18c, 8'h8f);
    chk({27'h0, nvc_o}, 32'h1f);
    wr(9'h101, 8'h6b);
    rd(9'h101, 8'h6b);
    chk({24'h0, tmr_o}, 32'h6b);
    rd(9'h18d, 8'h00);
    // indirect port through pointer 0x81 with irp set
    wr(9'h103, 8'h80);
    rd(9'h183, 8'h98);
    wr(9'h180, 8'ha5);
    rd(9'h181, 8'ha5);
    chk({24'h0, opt_o}, 32'ha5);
    rd(9'h100, 8'ha5);
    // direct window follows the bank select bits
    wr(9'h103, 8'he0);
    wr(9'h006, 8'h5a);
    rd(9'h186, 8'h5a);
    chk({24'h0, dir_o}, 32'h5a);
    wr(9'h103, 8'hc0);
    wr(9'h006, 8'h3c);
    chk({24'h0, latch_o}, 32'h3c);
    wr(9'h103, 8'h00);
    rd(9'h103, 8'h18);
    // bank 0 selected: a direct write lands nowhere here
    wr(9'h006, 8'h11);
    rd(9'h186, 8'h5a);
    chk({24'h0, latch_o}, 32'h3c);
    // flag results beat a same-cycle software write
    fl_upd <= 1'b1;
    z_in <= 1'b1;
    c_in <= 1'b1;
    // flag update drops right after the write edge, so the order shows
    fork
      wr(9'h103, 8'h02);
      begin
        do begin
          @(posedge clk_i);
        end while (ack_o !== 1'b1);
        fl_upd <= 1'b0;
      end
    join
    @(posedge clk_i);
    chk({24'h0, flags_o}, 32'h1d);
    core_evt(3'b100);
    chk({24'h0, flags_o}, 32'h0d);
    core_evt(3'b010);
    chk({24'h0, flags_o}, 32'h15);
    core_evt(3'b001);
    chk({24'h0, flags_o}, 32'h1d);
    // pins read back after synchronising
    pins <= 8'hc3;
    repeat (3) @(posedge clk_i);
    rd(9'h106, 8'hc3);
    wr(9'h18d, 8'h55);
    chk({24'h0, unl_d_o}, 32'h55);
    repeat (2) @(posedge clk_i);
    chk(unl_cnt, 32'h00000001);
    results();
  end
endmodule
`default_nettype wire
